// file: design/esm_pkg.sv
package esm_pkg;

  // controller time base
  localparam int CLK_KHZ         = 250000;
  localparam int TICK_MS         = 100;
  localparam int TICK_CYCLES_DEF = TICK_MS * CLK_KHZ;

  // bridge duration setting: 0 is off, n is n half-minutes up to 20
  localparam int           DUR_W          = 5;
  localparam int           HALF_MIN_S     = 30;
  localparam int           HALF_MIN_TICKS = HALF_MIN_S * 1000 / TICK_MS;
  localparam logic [4:0]   DUR_OFF        = 5'h00;
  localparam logic [4:0]   DUR_MAX_STEPS  = 5'h14;

  // rest position must be seen for this long before it counts
  localparam int           REST_MS        = 500;
  localparam int           REST_TICKS     = REST_MS / TICK_MS;

  localparam int           TIME_W         = 16;
  localparam logic [15:0]  TIME_RST       = 16'h0000;
  localparam int           DIAG_W         = 32;

  // diagnostics codes
  localparam logic [31:0] DG_NO_ENABLE   = 32'h0000_0000;
  localparam logic [31:0] DG_WAIT_INPUT  = 32'h0000_2001;
  localparam logic [31:0] DG_ONE_OPEN    = 32'h0000_2005;
  localparam logic [31:0] DG_SWITCH_OFF  = 32'h0000_2012;
  localparam logic [31:0] DG_SWITCH_ON   = 32'h0000_8002;
  localparam logic [31:0] DG_ERR_TIME    = 32'h0000_f002;
  localparam logic [31:0] DG_ERR_ONE     = 32'h0000_f00e;
  localparam logic [31:0] DG_ERR_UNDEF   = 32'h0000_f00f;

  typedef enum logic [2:0] {
    ESM_IDLE      = 3'b000,
    ESM_REST_WAIT = 3'b001,
    ESM_READY     = 3'b010,
    ESM_ENABLED   = 3'b011,
    ESM_ONE_OPEN  = 3'b100,
    ESM_ERR_TIME  = 3'b101,
    ESM_ERR_ONE   = 3'b110,
    ESM_ERR_UNDEF = 3'b111
  } esm_state_e;

  localparam esm_state_e STATE_RST = ESM_IDLE;

endpackage : esm_pkg

// file: design/esm_enable_switch.sv
module esm_enable_switch
  import esm_pkg::*;
#(
  parameter int INSTANCES   = 7,
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic [INSTANCES-1:0]        switch_channel_a_in,
  input  wire logic [INSTANCES-1:0]        switch_channel_b_in,
  input  wire logic [INSTANCES-1:0]        safety_activation_in,
  input  wire logic [INSTANCES-1:0]        ext_gate_in,
  input  wire logic [INSTANCES-1:0]        no_external_gate,
  input  wire logic [INSTANCES*DUR_W-1:0]  max_bridge_duration,
  output logic      [INSTANCES-1:0]        release_contact_out,
  output logic      [INSTANCES-1:0]        fault_contact_out,
  output logic      [INSTANCES*TIME_W-1:0] elapsed_bridge_time_out,
  output logic      [INSTANCES*DIAG_W-1:0] diag_word_out
);

  // elaboration checks on what the shared time base and counters can serve
  if (INSTANCES < 1 || INSTANCES > 7) begin : g_bad_instances
    $error("INSTANCES must be 1 to 7");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end
  if (HALF_MIN_TICKS * DUR_MAX_STEPS >= 2 ** TIME_W) begin : g_bad_limit
    $error("longest bridge limit does not fit the elapsed counter");
  end
  if (REST_TICKS < 1 || REST_TICKS > 15) begin : g_bad_rest
    $error("rest dwell does not fit its counter");
  end

  // limit in ticks; settings above ten minutes are held at ten
  function automatic logic [TIME_W-1:0] limit_ticks(input logic [DUR_W-1:0] dur);
    logic [DUR_W-1:0] steps;
    steps = (dur > DUR_MAX_STEPS) ? DUR_MAX_STEPS : dur;
    return TIME_W'(steps * HALF_MIN_TICKS);
  endfunction : limit_ticks

  function automatic logic [DIAG_W-1:0] diag_of(input esm_state_e st);
    logic [DIAG_W-1:0] code;
    code = DG_NO_ENABLE;
    unique case (st)
      ESM_IDLE:      code = DG_NO_ENABLE;
      ESM_REST_WAIT: code = DG_WAIT_INPUT;
      ESM_READY:     code = DG_SWITCH_OFF;
      ESM_ENABLED:   code = DG_SWITCH_ON;
      ESM_ONE_OPEN:  code = DG_ONE_OPEN;
      ESM_ERR_TIME:  code = DG_ERR_TIME;
      ESM_ERR_ONE:   code = DG_ERR_ONE;
      ESM_ERR_UNDEF: code = DG_ERR_UNDEF;
    endcase
    return code;
  endfunction : diag_of

  function automatic logic is_error(input esm_state_e st);
    return (st == ESM_ERR_TIME) || (st == ESM_ERR_ONE) || (st == ESM_ERR_UNDEF);
  endfunction : is_error

  // a synchronised pin level is trusted once stages two and three agree
  function automatic logic settled(input logic [2:0] stages);
    return stages[1] == stages[2];
  endfunction : settled

  localparam int PRE_W = $clog2(TICK_CYCLES);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  logic [PRE_W-1:0] pre_cnt_ff;
  logic             tick_ff;

  // shared controller time base
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_ff <= '0;
    end else if (pre_cnt_ff == PRE_LAST) begin
      pre_cnt_ff <= '0;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + PRE_W'(1);
    end
  end

  // one-cycle strobe per time-base period, seen by every instance together
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (pre_cnt_ff == PRE_LAST);
    end
  end

  for (genvar i = 0; i < INSTANCES; i++) begin : g_inst
    // pin path
    logic [2:0]        sync_a_ff;
    logic [2:0]        sync_b_ff;
    logic              chan_a_ff;
    logic              chan_b_ff;
    logic              a_settled;
    logic              b_settled;
    logic              both_closed;
    logic              both_open;

    // decision and timing
    esm_state_e        state_ff;
    esm_state_e        nxt_state;
    logic [TIME_W-1:0] elapsed_ff;
    logic [TIME_W-1:0] nxt_elapsed;
    logic [3:0]        rest_cnt_ff;
    logic              active;
    logic              rest_done;
    logic              limit_hit;
    logic [TIME_W-1:0] limit;

    // three-stage pin synchronisers, one per channel
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        sync_a_ff <= 3'h0;
      end else begin
        sync_a_ff <= {sync_a_ff[1:0], switch_channel_a_in[i]};
      end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        sync_b_ff <= 3'h0;
      end else begin
        sync_b_ff <= {sync_b_ff[1:0], switch_channel_b_in[i]};
      end
    end

    assign a_settled = settled(sync_a_ff);
    assign b_settled = settled(sync_b_ff);

    // a level counts once stages two and three agree; a lone bounce is ignored
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        chan_a_ff <= 1'b0;
      end else if (a_settled) begin
        chan_a_ff <= sync_a_ff[2];
      end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        chan_b_ff <= 1'b0;
      end else if (b_settled) begin
        chan_b_ff <= sync_b_ff[2];
      end
    end

    assign active = safety_activation_in[i] & (no_external_gate[i] | ext_gate_in[i]);
    assign both_closed = chan_a_ff & chan_b_ff;
    assign both_open   = ~chan_a_ff & ~chan_b_ff;
    assign rest_done   = (rest_cnt_ff >= 4'(REST_TICKS));
    assign limit       = limit_ticks(max_bridge_duration[i*DUR_W +: DUR_W]);
    assign limit_hit   = (limit != TIME_W'(DUR_OFF)) && (elapsed_ff >= limit);

    // rest position must dwell before it is trusted as position 0
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        rest_cnt_ff <= 4'h0;
      end else if (!both_open || state_ff != ESM_REST_WAIT) begin
        rest_cnt_ff <= 4'h0;
      end else if (tick_ff && !rest_done) begin
        rest_cnt_ff <= rest_cnt_ff + 4'h1;
      end
    end

    // deactivation wins over everything and also clears errors;
    // a channel closing alone in ESM_READY is an error at once, with no discrepancy window,
    // so contacts that close far apart must be wired to switch together
    always_comb begin
      nxt_state = state_ff;
      if (!active) begin
        nxt_state = ESM_IDLE;
      end else begin
        unique case (state_ff)
          ESM_IDLE: begin
            nxt_state = ESM_REST_WAIT;
          end
          ESM_REST_WAIT: begin
            if (both_open && rest_done) begin
              nxt_state = ESM_READY;
            end
          end
          ESM_READY: begin
            if (both_closed) begin
              nxt_state = ESM_ENABLED;
            end else if (!both_open) begin
              nxt_state = ESM_ERR_UNDEF;
            end
          end
          ESM_ENABLED: begin
            if (both_open) begin
              nxt_state = ESM_REST_WAIT;
            end else if (!both_closed) begin
              nxt_state = ESM_ONE_OPEN;
            end else if (limit_hit) begin
              nxt_state = ESM_ERR_TIME;
            end
          end
          ESM_ONE_OPEN: begin
            if (both_open) begin
              nxt_state = ESM_REST_WAIT;
            end else if (both_closed) begin
              nxt_state = ESM_ERR_ONE;
            end
          end
          ESM_ERR_TIME, ESM_ERR_ONE, ESM_ERR_UNDEF: begin
            if (both_open) begin
              nxt_state = ESM_REST_WAIT;
            end
          end
        endcase
      end
    end

    always_comb begin
      nxt_elapsed = TIME_RST;
      if (nxt_state == ESM_ENABLED && state_ff == ESM_ENABLED) begin
        nxt_elapsed = elapsed_ff;
        if (tick_ff && elapsed_ff != '1) begin
          nxt_elapsed = elapsed_ff + TIME_W'(1);
        end
      end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        state_ff <= STATE_RST;
      end else begin
        state_ff <= nxt_state;
      end
    end

    // elapsed restarts from zero on every new enable
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        elapsed_ff <= TIME_RST;
      end else begin
        elapsed_ff <= nxt_elapsed;
      end
    end

    // contacts and words are registered from the next state, so they move with state_ff
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        release_contact_out[i] <= 1'b0;
      end else begin
        release_contact_out[i] <= (nxt_state == ESM_ENABLED);
      end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        fault_contact_out[i] <= 1'b0;
      end else begin
        fault_contact_out[i] <= is_error(nxt_state);
      end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        elapsed_bridge_time_out[i*TIME_W +: TIME_W] <= TIME_RST;
      end else begin
        elapsed_bridge_time_out[i*TIME_W +: TIME_W] <= nxt_elapsed;
      end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        diag_word_out[i*DIAG_W +: DIAG_W] <= DG_NO_ENABLE;
      end else begin
        diag_word_out[i*DIAG_W +: DIAG_W] <= diag_of(nxt_state);
      end
    end
  end : g_inst

endmodule : esm_enable_switch

// file: verif/esm_enable_switch_asserts.sv
module esm_enable_switch_asserts
  import esm_pkg::*;
#(
  parameter int INSTANCES   = 7,
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic                        mclk,
  input wire logic                        rst_b,
  input wire logic [INSTANCES-1:0]        switch_channel_a_in,
  input wire logic [INSTANCES-1:0]        switch_channel_b_in,
  input wire logic [INSTANCES-1:0]        safety_activation_in,
  input wire logic [INSTANCES*DUR_W-1:0]  max_bridge_duration,
  input wire logic [INSTANCES-1:0]        release_contact_out,
  input wire logic [INSTANCES-1:0]        fault_contact_out,
  input wire logic [INSTANCES*TIME_W-1:0] elapsed_bridge_time_out,
  input wire logic [INSTANCES*DIAG_W-1:0] diag_word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire        rel = release_contact_out[0];
  wire [15:0] el  = elapsed_bridge_time_out[15:0];
  wire [31:0] dg  = diag_word_out[31:0];
  property p_idle; !safety_activation_in[0] |=> !rel && !fault_contact_out[0]; endproperty
  a_idle: assert property (p_idle) else $error("outputs not idle");
  property p_diag_idle; !safety_activation_in[0] |=> dg == DG_NO_ENABLE; endproperty
  a_diag_idle: assert property (p_diag_idle) else $error("idle code wrong");
  property p_start; $rose(rel) |-> el == TIME_RST; endproperty
  a_start: assert property (p_start) else $error("elapsed not cleared at enable");
  property p_both; rel |-> $past(switch_channel_a_in[0] & switch_channel_b_in[0], 5); endproperty
  a_both: assert property (p_both) else $error("enable without both channels");
  property p_err; dg[15:12] == 4'hf |-> fault_contact_out[0]; endproperty
  a_err: assert property (p_err) else $error("error code without fault");
  property p_on; rel |-> dg == DG_SWITCH_ON; endproperty
  a_on: assert property (p_on) else $error("enable with wrong code");
  property p_stay; $fell(rel) |-> !rel [*8]; endproperty
  a_stay: assert property (p_stay) else $error("enable came back");
  property p_lim; rel && max_bridge_duration[4:0] == 5'h01 |-> el <= 16'h012c; endproperty
  a_lim: assert property (p_lim) else $error("limit overrun");
  property p_one; dg == DG_ONE_OPEN |-> !rel; endproperty
  a_one: assert property (p_one) else $error("enable while one open");
  c_on: cover property ($rose(rel));
  c_flt: cover property ($rose(fault_contact_out[0]));
  c_one: cover property (dg == DG_ERR_ONE);
endmodule : esm_enable_switch_asserts

bind esm_enable_switch esm_enable_switch_asserts #(
  .INSTANCES(INSTANCES), .TICK_CYCLES(TICK_CYCLES)
) u_asr (
  .mclk(mclk), .rst_b(rst_b), .switch_channel_a_in(switch_channel_a_in),
  .switch_channel_b_in(switch_channel_b_in), .safety_activation_in(safety_activation_in),
  .max_bridge_duration(max_bridge_duration), .release_contact_out(release_contact_out),
  .fault_contact_out(fault_contact_out), .elapsed_bridge_time_out(elapsed_bridge_time_out),
  .diag_word_out(diag_word_out)
);

// file: verif/esm_switch_model.sv
module esm_switch_model #(
  parameter int N = 2
) (
  input  wire logic [2*N-1:0] pos,
  output logic      [N-1:0]   ch_a,
  output logic      [N-1:0]   ch_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // 0 rest and 2 panic open both make contacts, 1 middle closes both, 3 closes a only
  always_comb begin
    for (int i = 0; i < N; i++) begin
      ch_a[i] = pos[2*i +: 2] == 2'h1 || pos[2*i +: 2] == 2'h3;
      ch_b[i] = pos[2*i +: 2] == 2'h1;
    end
  end
endmodule : esm_switch_model

// file: verif/esm_enable_switch_tb_top.sv
module esm_enable_switch_tb_top;
  import esm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk  = 1'b0;
  logic        rst_b = 1'b0;
  logic [1:0]  sa    = 2'h3;
  logic [1:0]  gate  = 2'h0;
  logic [1:0]  neg   = 2'h1;
  logic [3:0]  pos   = 4'h0;
  logic [9:0]  dur   = 10'h000;
  logic [1:0]  a, b, rel, flt;
  logic [31:0] el;
  logic [63:0] dg;
  int          miscompares = 0;
  int          compares    = 0;
  always #2 mclk = ~mclk;
  esm_switch_model #(.N(2)) u_sw (.pos(pos), .ch_a(a), .ch_b(b));
  esm_enable_switch #(.INSTANCES(2), .TICK_CYCLES(4)) DUT (
    .mclk(mclk), .rst_b(rst_b), .switch_channel_a_in(a), .switch_channel_b_in(b),
    .safety_activation_in(sa), .ext_gate_in(gate), .no_external_gate(neg),
    .max_bridge_duration(dur), .release_contact_out(rel), .fault_contact_out(flt),
    .elapsed_bridge_time_out(el), .diag_word_out(dg)
  );
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic go(input logic [1:0] p, input int n);
    @(posedge mclk);
    pos[1:0] <= p;
    repeat (n) @(posedge mclk);
    #1;
  endtask : go
  task automatic t_normal();
    go(2'h0, 40);
    chk("diag rest", DG_SWITCH_OFF, dg[31:0]);
    go(2'h1, 40);
    chk("rel mid", 32'h1, rel[0]);
    chk("elapsed", 32'h1, el[15:0] != 16'h0);
    go(2'h2, 8);
    chk("rel panic", 32'h0, rel[0]);
    chk("elapsed panic", 32'h0, el[15:0]);
    go(2'h1, 8);
    chk("rel back mid", 32'h0, rel[0]);
    go(2'h0, 40);
    chk("diag rest2", DG_SWITCH_OFF, dg[31:0]);
  endtask : t_normal
  task automatic t_one();
    go(2'h1, 8);
    go(2'h3, 8);
    chk("diag one", DG_ONE_OPEN, dg[31:0]);
    chk("rel one", 32'h0, rel[0]);
    go(2'h1, 8);
    chk("diag err one", DG_ERR_ONE, dg[31:0]);
    chk("fault one", 32'h1, flt[0]);
    go(2'h0, 40);
    chk("fault ack", 32'h0, flt[0]);
  endtask : t_one
  task automatic t_limit();
    @(posedge mclk);
    dur[4:0] <= 5'h01;
    go(2'h1, 1240);
    chk("diag time", DG_ERR_TIME, dg[31:0]);
    chk("rel time", 32'h0, rel[0]);
    chk("elapsed time", 32'h0, el[15:0]);
    go(2'h0, 40);
    chk("diag ack", DG_SWITCH_OFF, dg[31:0]);
  endtask : t_limit
  task automatic t_gate();
    @(posedge mclk);
    neg[1] <= 1'b0;
    go(2'h0, 40);
    chk("gate off", DG_NO_ENABLE, dg[63:32]);
    chk("gate off rel", 32'h0, rel[1]);
    @(posedge mclk);
    gate[1] <= 1'b1;
    go(2'h0, 40);
    chk("gate on", DG_SWITCH_OFF, dg[63:32]);
    @(posedge mclk);
    sa[0] <= 1'b0;
    go(2'h1, 20);
    chk("no safety", DG_NO_ENABLE, dg[31:0]);
    chk("no safety rel", 32'h0, rel[0]);
  endtask : t_gate
  task automatic end_of_test();
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    chk("reset diag", DG_NO_ENABLE, dg[31:0]);
    t_normal();
    t_one();
    t_limit();
    t_gate();
    end_of_test();
  end
  initial begin
    #40000;
    miscompares++;
    end_of_test();
  end
endmodule : esm_enable_switch_tb_top
